// ### rtl/sln_far_port.sv
`timescale 1ns/1ps
`include "sln_params.svh"

module sln_far_port
  import sln_pkg::*;
#(
  parameter int HALF_CYC = `SLN_LINK_HALF_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  sln_link_if.far_end     link,
  input  wire logic       half_rate,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic       tx_k,
  input  wire logic [7:0] tx_byte,
  output logic            rx_valid,
  output logic            rx_k,
  output logic [7:0]      rx_byte,
  output logic            rx_bad
);

  logic        c_s1, c_s2, c_s3, d_s1, d_s2;
  sln_char_t   rx_sr, next_rx_sr, tx_sr, next_tx_sr;
  logic [3:0]  rx_cnt, next_rx_cnt, tx_bit, next_tx_bit;
  logic [15:0] tx_div, next_tx_div, half_lim;
  logic        rx_lock, next_rx_lock, lclk, next_lclk, after_flag, next_after_flag;
  logic        next_rx_valid, next_rx_k, next_rx_bad;
  logic [7:0]  next_rx_byte;

  assign link.dn_clk  = lclk;
  assign link.dn_data = tx_sr[9];
  assign half_lim     = half_rate ? 16'(HALF_CYC * 2 - 1) : 16'(HALF_CYC - 1);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      c_s1 <= 1'b0;
      c_s2 <= 1'b0;
      c_s3 <= 1'b0;
      d_s1 <= 1'b0;
      d_s2 <= 1'b0;
    end else begin
      c_s1 <= link.up_clk;
      c_s2 <= c_s1;
      c_s3 <= c_s2;
      d_s1 <= link.up_data;
      d_s2 <= d_s1;
    end
  end

  always_comb begin
    sln_char_t  sh;
    logic [7:0] b;
    sh              = '0;
    b               = tx_byte;
    next_rx_sr      = rx_sr;
    next_rx_cnt     = rx_cnt;
    next_rx_lock    = rx_lock;
    next_rx_valid   = 1'b0;
    next_rx_k       = rx_k;
    next_rx_byte    = rx_byte;
    next_rx_bad     = 1'b0;
    next_tx_sr      = tx_sr;
    next_tx_bit     = tx_bit;
    next_tx_div     = tx_div + 16'h0001;
    next_lclk       = lclk;
    next_after_flag = after_flag;
    tx_ready        = 1'b0;
    if (c_s2 && !c_s3) begin
      sh         = {rx_sr[8:0], d_s2};
      next_rx_sr = sh;
      if (rx_lock ? (rx_cnt == 4'h9) : sln_is_k(sh, `SLN_K_FLAG)) begin
        next_rx_cnt   = 4'h0;
        next_rx_lock  = !sln_bad(sh);
        next_rx_valid = 1'b1;
        next_rx_k     = sh[9];
        next_rx_byte  = sh[7:0];
        next_rx_bad   = sln_bad(sh);
      end else begin
        next_rx_cnt = rx_cnt + 4'h1;
      end
    end
    if (tx_div == half_lim) begin
      next_tx_div = 16'h0000;
      next_lclk   = !lclk;
      if (lclk && tx_bit != 4'h9) begin
        next_tx_bit = tx_bit + 4'h1;
        next_tx_sr  = {tx_sr[8:0], 1'b0};
      end else if (lclk) begin
        next_tx_bit = 4'h0;
        tx_ready    = 1'b1;
        if (!tx_valid) begin
          next_tx_sr = sln_enc(1'b1, `SLN_K_NUL);
        end else begin
          if (!tx_k && after_flag) begin
            b = tx_byte & ~`SLN_CTL_RSVD_MASK;
          end
          next_tx_sr      = sln_enc(tx_k, b);
          next_after_flag = tx_k && (tx_byte == `SLN_K_FLAG);
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_sr      <= '0;
      rx_cnt     <= 4'h0;
      rx_lock    <= 1'b0;
      rx_valid   <= 1'b0;
      rx_k       <= 1'b0;
      rx_byte    <= 8'h00;
      rx_bad     <= 1'b0;
      tx_sr      <= '0;
      tx_bit     <= 4'h9;
      tx_div     <= 16'h0000;
      lclk       <= 1'b0;
      after_flag <= 1'b0;
    end else begin
      rx_sr      <= next_rx_sr;
      rx_cnt     <= next_rx_cnt;
      rx_lock    <= next_rx_lock;
      rx_valid   <= next_rx_valid;
      rx_k       <= next_rx_k;
      rx_byte    <= next_rx_byte;
      rx_bad     <= next_rx_bad;
      tx_sr      <= next_tx_sr;
      tx_bit     <= next_tx_bit;
      tx_div     <= next_tx_div;
      lclk       <= next_lclk;
      after_flag <= next_after_flag;
    end
  end

endmodule

// ### rtl/sln_link_if.sv
`timescale 1ns/1ps

interface sln_link_if;
  logic dn_data;
  logic dn_clk;
  logic up_data;
  logic up_clk;

  modport node_end (input dn_data, input dn_clk, output up_data, output up_clk);
  modport far_end  (output dn_data, output dn_clk, input up_data, input up_clk);
endinterface

// ### rtl/sln_node_router.sv
`timescale 1ns/1ps
`include "sln_params.svh"

// What this block does
// - originated frames carry reserved bits as zero
// - forwarding ignores reserved bits and values
// - reserved frame or reset type: frame reject
// - message with reserved bits set: reject answer
// - ignored bits accepted with any value
// - characters leave bit a first, j last
// - bit 7 is msb, bit 0 lsb
// - multi-byte numbers go most significant first
// - line runs at 400 or 200 Mb/s; the default divider gives 12.5 or 6.25 Mb/s
// - frame overhead eight characters, duplex four more
// - ack time-out 25 us, extended 100 us
// - receiver recovers timing, synchronised against metastability
// - only configurators may be master, one only
// - address decides local delivery or other port
// - node function picks the originating port
// - links independent; errors only abort forwarded frames
// - string holds at most 129 nodes
// - loop holds at most 128 nodes
// - loops contain dual port nodes only
// - zero path byte means frame is ours
// - frame needs six or more data characters
// - foreign frames cut through with minimal latency

module sln_node_router
  import sln_pkg::*;
#(
  parameter int HALF_CYC   = `SLN_LINK_HALF_CYC,
  parameter int ACK_TO_STD = `SLN_ACK_STD_CYC,
  parameter int ACK_TO_EXT = `SLN_ACK_EXT_CYC,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic            core_clk,
  input  wire logic            rst,
  sln_link_if.node_end         port0,
  sln_link_if.node_end         port1,
  input  wire logic            half_rate,
  input  wire logic            ext_distance,
  input  wire logic            is_configurator,
  input  wire logic            master_grant,
  output logic                 is_master,
  input  wire logic            loc_tx_valid,
  output logic                 loc_tx_ready,
  input  wire logic [7:0]      loc_tx_data,
  input  wire logic            loc_tx_last,
  input  wire logic            loc_tx_port,
  output logic [1:0]           loc_rx_valid,
  output logic [1:0][7:0]      loc_rx_data,
  output logic [1:0]           loc_rx_first,
  output logic [1:0]           loc_rx_end,
  output logic [1:0]           frame_reject,
  output logic [1:0]           msg_reject,
  output logic [1:0]           runt_frame,
  output logic [1:0]           fwd_abort,
  output logic [1:0]           ack_timeout
);

  localparam int AW = $clog2(FIFO_DEPTH);

  // ****************************************
  // state, one copy per port
  // ****************************************
  logic [1:0]   c_s1, c_s2, c_s3, d_s1, d_s2;
  sln_char_t    rx_sr [2], next_rx_sr [2], rx_chr [2], next_rx_chr [2];
  logic [3:0]   rx_cnt [2], next_rx_cnt [2], tx_bit [2], next_tx_bit [2];
  logic [1:0]   rx_lock, next_rx_lock, rx_stb, next_rx_stb;
  sln_route_t   rt [2], next_rt [2];
  logic [7:0]   fr_cnt [2], next_fr_cnt [2], ctl [2], next_ctl [2], addr [2], next_addr [2];
  logic [1:0]   hdr_cnt [2], next_hdr_cnt [2];
  sln_char_t    mem [2][FIFO_DEPTH], next_mem [2][FIFO_DEPTH];
  logic [AW-1:0] wp [2], next_wp [2], rp [2], next_rp [2];
  logic [AW:0]  fcnt [2], next_fcnt [2];
  sln_char_t    tx_sr [2], next_tx_sr [2];
  logic [15:0]  tx_div [2], next_tx_div [2], ack_tmr [2], next_ack_tmr [2], half_lim;
  logic [1:0]   lclk, next_lclk, lx_open, next_lx_open, lx_first, next_lx_first;
  logic [1:0]   lx_close, next_lx_close, abort_pend, next_abort_pend, ack_run, next_ack_run;
  logic [1:0]   push_v;
  sln_char_t    push_c [2];
  logic [1:0]   next_loc_rx_valid, next_loc_rx_first, next_loc_rx_end, next_frame_reject;
  logic [1:0]   next_msg_reject, next_runt_frame, next_fwd_abort, next_ack_timeout;
  logic [1:0][7:0] next_loc_rx_data;
  logic [1:0]   dn_clk, dn_data;

  // ****************************************
  // pins
  // ****************************************
  assign dn_clk        = {port1.dn_clk, port0.dn_clk};
  assign dn_data       = {port1.dn_data, port0.dn_data};
  assign port0.up_clk  = lclk[0];
  assign port1.up_clk  = lclk[1];
  assign port0.up_data = tx_sr[0][9];
  assign port1.up_data = tx_sr[1][9];
  assign half_lim      = half_rate ? 16'(HALF_CYC * 2 - 1) : 16'(HALF_CYC - 1);

  // both link pins cross into core_clk through two flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      c_s1 <= 2'h0;
      c_s2 <= 2'h0;
      c_s3 <= 2'h0;
      d_s1 <= 2'h0;
      d_s2 <= 2'h0;
    end else begin
      c_s1 <= dn_clk;
      c_s2 <= c_s1;
      c_s3 <= c_s2;
      d_s1 <= dn_data;
      d_s2 <= d_s1;
    end
  end

  // ****************************************
  // receivers, router, transmitters
  // ****************************************
  always_comb begin
    sln_char_t  sh;
    sln_char_t  c;
    logic [7:0] b;
    logic       slot;
    logic       pop;
    logic       pushed;
    sh = '0;
    c = '0;
    b = 8'h00;
    slot = 1'b0;
    pop = 1'b0;
    pushed = 1'b0;
    next_rx_sr = rx_sr;
    next_rx_chr = rx_chr;
    next_rx_cnt = rx_cnt;
    next_rx_lock = rx_lock;
    next_rx_stb = 2'h0;
    next_rt = rt;
    next_fr_cnt = fr_cnt;
    next_ctl = ctl;
    next_addr = addr;
    next_hdr_cnt = hdr_cnt;
    next_mem = mem;
    next_wp = wp;
    next_rp = rp;
    next_fcnt = fcnt;
    next_tx_sr = tx_sr;
    next_tx_bit = tx_bit;
    next_tx_div = tx_div;
    next_lclk = lclk;
    next_ack_tmr = ack_tmr;
    next_ack_run = ack_run;
    next_lx_open = lx_open;
    next_lx_first = lx_first;
    next_lx_close = lx_close;
    next_abort_pend = abort_pend;
    next_loc_rx_valid = 2'h0;
    next_loc_rx_data = loc_rx_data;
    next_loc_rx_first = 2'h0;
    next_loc_rx_end = 2'h0;
    next_frame_reject = 2'h0;
    next_msg_reject = 2'h0;
    next_runt_frame = 2'h0;
    next_fwd_abort = 2'h0;
    next_ack_timeout = 2'h0;
    push_v = 2'h0;
    push_c[0] = '0;
    push_c[1] = '0;
    loc_tx_ready = 1'b0;
    for (int i = 0; i < 2; i++) begin
      // character alignment hunts for the flag pattern
      if (c_s2[i] && !c_s3[i]) begin
        sh = {rx_sr[i][8:0], d_s2[i]};
        next_rx_sr[i] = sh;
        if (rx_lock[i] ? (rx_cnt[i] == 4'h9) : sln_is_k(sh, `SLN_K_FLAG)) begin
          next_rx_cnt[i]  = 4'h0;
          next_rx_lock[i] = !sln_bad(sh);
          next_rx_stb[i]  = 1'b1;
          next_rx_chr[i]  = sh;
        end else begin
          next_rx_cnt[i] = rx_cnt[i] + 4'h1;
        end
      end
      c = rx_chr[i];
      b = c[7:0];
      if (rx_stb[i]) begin
        if (sln_bad(c) || sln_is_k(c, `SLN_K_ABORT)) begin
          if (rt[i] == RT_FWD) begin
            next_abort_pend[1-i] = 1'b1;
            next_fwd_abort[i]    = 1'b1;
          end
          next_rt[i] = RT_IDLE;
        end else if (sln_is_k(c, `SLN_K_FLAG)) begin
          if (rt[i] == RT_LOCAL) begin
            next_loc_rx_end[i] = 1'b1;
            next_runt_frame[i] = fr_cnt[i] < 8'(`SLN_MIN_DATA_CHARS);
          end
          if (rt[i] == RT_FWD) begin
            push_v[1-i] = 1'b1;
            push_c[1-i] = c;
          end
          next_rt[i]     = RT_CTRL;
          next_fr_cnt[i] = 8'h00;
        end else if (!c[9]) begin
          if (fr_cnt[i] != 8'hFF) begin
            next_fr_cnt[i] = fr_cnt[i] + 8'h01;
          end
          case (rt[i])
            RT_CTRL: begin
              next_ctl[i] = b;
              next_rt[i]  = RT_ADDR;
            end
            RT_ADDR: begin
              if (b != `SLN_PATH_LOCAL) begin
                next_rt[i]      = RT_FWD;
                next_addr[i]    = b - 8'h01;
                next_hdr_cnt[i] = 2'h3;
              end else if (ctl[i][`SLN_FT_POS+:2] == `SLN_FT_RSVD ||
                           (ctl[i][`SLN_FT_POS+:2] == `SLN_FT_CONTROL &&
                            ctl[i][`SLN_RT_POS+:2] == `SLN_RT_RSVD)) begin
                next_frame_reject[i] = 1'b1;
                next_rt[i]           = RT_DROP;
              end else begin
                next_rt[i] = RT_LOCAL;
              end
            end
            RT_LOCAL: begin
              next_loc_rx_valid[i] = 1'b1;
              next_loc_rx_data[i]  = b;
              next_loc_rx_first[i] = fr_cnt[i] == 8'h02;
              // ignored control bit stays out of the mask
              next_msg_reject[i] = fr_cnt[i] == 8'h02 && b == `SLN_CHAN_MSG &&
                                   (ctl[i] & `SLN_CTL_RSVD_MASK) != 8'h00;
            end
            RT_FWD: begin
              push_v[1-i] = 1'b1;
              push_c[1-i] = c;
            end
            default: begin
            end
          endcase
        end
      end else if (hdr_cnt[i] != 2'h0) begin
        // rebuilds flag, control and decremented path ahead of the body
        push_v[1-i] = 1'b1;
        push_c[1-i] = (hdr_cnt[i] == 2'h3) ? sln_enc(1'b1, `SLN_K_FLAG) :
                      (hdr_cnt[i] == 2'h2) ? sln_enc(1'b0, ctl[i]) : sln_enc(1'b0, addr[i]);
        next_hdr_cnt[i] = hdr_cnt[i] - 2'h1;
      end
    end
    for (int p = 0; p < 2; p++) begin
      slot = 1'b0;
      pop = 1'b0;
      pushed = 1'b0;
      if (ack_run[p]) begin
        if (rx_stb[p] && sln_is_k(rx_chr[p], `SLN_K_ACK)) begin
          next_ack_run[p] = 1'b0;
        end else if (ack_tmr[p] == 16'h0000) begin
          next_ack_timeout[p] = 1'b1;
          next_ack_run[p]     = 1'b0;
        end else begin
          next_ack_tmr[p] = ack_tmr[p] - 16'h0001;
        end
      end
      if (tx_div[p] == half_lim) begin
        next_tx_div[p] = 16'h0000;
        next_lclk[p]   = !lclk[p];
        if (lclk[p] && tx_bit[p] != 4'h9) begin
          next_tx_bit[p] = tx_bit[p] + 4'h1;
          next_tx_sr[p]  = {tx_sr[p][8:0], 1'b0};
        end else if (lclk[p]) begin
          next_tx_bit[p] = 4'h0;
          slot = 1'b1;
        end
      end else begin
        next_tx_div[p] = tx_div[p] + 16'h0001;
      end
      next_tx_sr[p] = slot ? sln_enc(1'b1, `SLN_K_NUL) : next_tx_sr[p];
      if (slot && abort_pend[p]) begin
        next_tx_sr[p]      = sln_enc(1'b1, `SLN_K_ABORT);
        next_abort_pend[p] = 1'b0;
      end else if (slot && lx_open[p]) begin
        loc_tx_ready = loc_tx_port == 1'(p);
        if (loc_tx_valid && loc_tx_port == 1'(p)) begin
          b = lx_first[p] ? (loc_tx_data & ~`SLN_CTL_RSVD_MASK) : loc_tx_data;
          next_tx_sr[p]    = sln_enc(1'b0, b);
          next_lx_first[p] = 1'b0;
          next_lx_open[p]  = !loc_tx_last;
          next_lx_close[p] = loc_tx_last;
        end
      end else if (slot && lx_close[p]) begin
        next_tx_sr[p]    = sln_enc(1'b1, `SLN_K_FLAG);
        next_lx_close[p] = 1'b0;
        next_ack_run[p]  = 1'b1;
        next_ack_tmr[p]  = ext_distance ? 16'(ACK_TO_EXT) : 16'(ACK_TO_STD);
      end else if (slot && fcnt[p] != '0) begin
        next_tx_sr[p] = mem[p][rp[p]];
        pop = 1'b1;
      end else if (slot && loc_tx_valid && loc_tx_port == 1'(p) &&
                   rt[1-p] != RT_FWD && hdr_cnt[1-p] == 2'h0) begin
        next_tx_sr[p]    = sln_enc(1'b1, `SLN_K_FLAG);
        next_lx_open[p]  = 1'b1;
        next_lx_first[p] = 1'b1;
      end
      if (pop) begin
        next_rp[p] = rp[p] + 1'b1;
      end
      if (push_v[p]) begin
        if (fcnt[p] == (AW+1)'(FIFO_DEPTH) && !pop) begin
          // overrun kills only the frame in transit
          next_abort_pend[p] = 1'b1;
          next_fwd_abort[1-p] = 1'b1;
          next_rt[1-p]        = RT_DROP;
          next_hdr_cnt[1-p]   = 2'h0;
        end else begin
          next_mem[p][wp[p]] = push_c[p];
          next_wp[p]         = wp[p] + 1'b1;
          pushed             = 1'b1;
        end
      end
      next_fcnt[p] = fcnt[p] + (AW+1)'(pushed) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int p = 0; p < 2; p++) begin
        rx_sr[p]   <= '0;
        rx_chr[p]  <= '0;
        rx_cnt[p]  <= 4'h0;
        rt[p]      <= RT_IDLE;
        fr_cnt[p]  <= 8'h00;
        ctl[p]     <= 8'h00;
        addr[p]    <= 8'h00;
        hdr_cnt[p] <= 2'h0;
        wp[p]      <= '0;
        rp[p]      <= '0;
        fcnt[p]    <= '0;
        tx_sr[p]   <= '0;
        tx_bit[p]  <= 4'h9;
        tx_div[p]  <= 16'h0000;
        ack_tmr[p] <= 16'h0000;
        for (int k = 0; k < FIFO_DEPTH; k++) begin
          mem[p][k] <= '0;
        end
      end
      rx_lock      <= 2'h0;
      rx_stb       <= 2'h0;
      lclk         <= 2'h0;
      lx_open      <= 2'h0;
      lx_first     <= 2'h0;
      lx_close     <= 2'h0;
      abort_pend   <= 2'h0;
      ack_run      <= 2'h0;
      loc_rx_valid <= 2'h0;
      loc_rx_data  <= '0;
      loc_rx_first <= 2'h0;
      loc_rx_end   <= 2'h0;
      frame_reject <= 2'h0;
      msg_reject   <= 2'h0;
      runt_frame   <= 2'h0;
      fwd_abort    <= 2'h0;
      ack_timeout  <= 2'h0;
      is_master    <= 1'b0;
    end else begin
      rx_sr        <= next_rx_sr;
      rx_chr       <= next_rx_chr;
      rx_cnt       <= next_rx_cnt;
      rt           <= next_rt;
      fr_cnt       <= next_fr_cnt;
      ctl          <= next_ctl;
      addr         <= next_addr;
      hdr_cnt      <= next_hdr_cnt;
      mem          <= next_mem;
      wp           <= next_wp;
      rp           <= next_rp;
      fcnt         <= next_fcnt;
      tx_sr        <= next_tx_sr;
      tx_bit       <= next_tx_bit;
      tx_div       <= next_tx_div;
      ack_tmr      <= next_ack_tmr;
      rx_lock      <= next_rx_lock;
      rx_stb       <= next_rx_stb;
      lclk         <= next_lclk;
      lx_open      <= next_lx_open;
      lx_first     <= next_lx_first;
      lx_close     <= next_lx_close;
      abort_pend   <= next_abort_pend;
      ack_run      <= next_ack_run;
      loc_rx_valid <= next_loc_rx_valid;
      loc_rx_data  <= next_loc_rx_data;
      loc_rx_first <= next_loc_rx_first;
      loc_rx_end   <= next_loc_rx_end;
      frame_reject <= next_frame_reject;
      msg_reject   <= next_msg_reject;
      runt_frame   <= next_runt_frame;
      fwd_abort    <= next_fwd_abort;
      ack_timeout  <= next_ack_timeout;
      is_master    <= is_configurator && master_grant;
    end
  end

endmodule

// ### rtl/sln_params.svh
`ifndef SLN_PARAMS_SVH
`define SLN_PARAMS_SVH

// ****************************************
// characters and special codes
// ****************************************
`define SLN_CHAR_W          10
`define SLN_K_FLAG          8'h3C
`define SLN_K_ABORT         8'h5C
`define SLN_K_ACK           8'hF7
`define SLN_K_RR            8'hFB
`define SLN_K_NUL           8'hFD

// ****************************************
// control byte fields
// ****************************************
`define SLN_FT_POS          6
`define SLN_FT_CONTROL      2'h1
`define SLN_FT_RSVD         2'h3
`define SLN_RT_POS          4
`define SLN_RT_RSVD         2'h3
`define SLN_CTL_IGN_BIT     3
`define SLN_CTL_RSVD_MASK   8'h07
`define SLN_CHAN_MSG        8'h00
`define SLN_PATH_LOCAL      8'h00

// ****************************************
// frame and topology figures
// ****************************************
`define SLN_MIN_DATA_CHARS  6
`define SLN_FRAME_OVH_CHARS 8
`define SLN_DUPLEX_OVH_CHARS 4
`define SLN_MAX_STRING_NODES 129
`define SLN_MAX_LOOP_NODES  128

// ****************************************
// timing
// ****************************************
`define SLN_CLK_MHZ         200
`define SLN_RATE_FULL_MBPS  400
`define SLN_RATE_HALF_MBPS  200
`define SLN_LINK_HALF_NS    40
`define SLN_LINK_HALF_CYC   ((`SLN_LINK_HALF_NS * `SLN_CLK_MHZ + 999) / 1000)
`define SLN_ACK_STD_US      25
`define SLN_ACK_EXT_US      100
`define SLN_ACK_STD_CYC     (`SLN_ACK_STD_US * `SLN_CLK_MHZ)
`define SLN_ACK_EXT_CYC     (`SLN_ACK_EXT_US * `SLN_CLK_MHZ)

`endif

// ### rtl/sln_pkg.sv
`include "sln_params.svh"

package sln_pkg;

  typedef logic [`SLN_CHAR_W-1:0] sln_char_t;

  typedef enum logic [5:0] {
    RT_IDLE  = 6'h01,
    RT_CTRL  = 6'h02,
    RT_ADDR  = 6'h04,
    RT_LOCAL = 6'h08,
    RT_FWD   = 6'h10,
    RT_DROP  = 6'h20
  } sln_route_t;

  // stand-in line code: bit a flags special, bit b its complement
  function automatic sln_char_t sln_enc(input logic k, input logic [7:0] b);
    return {k, ~k, b};
  endfunction

  function automatic logic sln_bad(input sln_char_t c);
    return c[9] == c[8];
  endfunction

  function automatic logic sln_is_k(input sln_char_t c, input logic [7:0] code);
    return c == sln_enc(1'b1, code);
  endfunction

endpackage

// ### verif/sln_link_assertions.sv
`timescale 1ns/1ps

module sln_link_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic dn_data,
  input wire logic dn_clk,
  input wire logic up_data,
  input wire logic up_clk,
  input wire logic half_rate
);
  // ****************************************
  // link wire checks, bench runs two cycles a half period, four at half rate
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_up_idle_reset: assert property (disable iff (1'b0) rst |=> !up_clk && !up_data)
    else $error("up link not idle after reset");
  a_dn_idle_reset: assert property (disable iff (1'b0) rst |=> !dn_clk && !dn_data)
    else $error("down link not idle after reset");
  a_up_data_fall: assert property ($changed(up_data) |-> !up_clk)
    else $error("up data moved while clock high");
  a_dn_data_fall: assert property ($changed(dn_data) |-> !dn_clk)
    else $error("down data moved while clock high");
  a_up_high_time: assert property (!half_rate && $rose(up_clk) |=> up_clk ##1 !up_clk)
    else $error("up clock high time wrong");
  a_up_low_time: assert property (!half_rate && $fell(up_clk) |=> !up_clk ##1 up_clk)
    else $error("up clock low time wrong");
  a_dn_high_time: assert property (!half_rate && $rose(dn_clk) |=> dn_clk ##1 !dn_clk)
    else $error("down clock high time wrong");
  a_dn_low_time: assert property (!half_rate && $fell(dn_clk) |=> !dn_clk ##1 dn_clk)
    else $error("down clock low time wrong");
  a_up_slow_high: assert property (half_rate && $rose(up_clk) |=> up_clk[*3] ##1 !up_clk)
    else $error("up clock high time wrong at half rate");
  a_dn_slow_low: assert property (half_rate && $fell(dn_clk) |=> (!dn_clk)[*3] ##1 dn_clk)
    else $error("down clock low time wrong at half rate");
endmodule

// ### verif/sln_node_router_tb.sv
`timescale 1ns/1ps
`include "sln_params.svh"

module sln_node_router_tb;
  import sln_pkg::*;
  // ****************************************
  // stimulus and wiring
  // ****************************************
  logic core_clk = 0, rst = 1, cfg = 0, grant = 0, lv = 0, ll = 0, lp = 0, rej_seen = 0, runt_seen = 0;
  logic hr = 0, ed = 0;
  logic [7:0] ld = 0;
  logic [1:0] fv = 0, fk = 0;
  logic [1:0][7:0] fb = 0;
  wire mst, lr;
  wire [1:0] rv, fr, at, ftr, frv, frk, rf;
  wire [1:0][7:0] rd, fd;
  int n_fail = 0, checks_done = 0, n_tout = 0;
  sln_link_if lk [2] ();
  always #2.5 core_clk = ~core_clk;
  sln_node_router #(.HALF_CYC(2), .ACK_TO_STD(50), .ACK_TO_EXT(200)) u_sln_node_router (.core_clk, .rst,
    .port0(lk[0]), .port1(lk[1]), .half_rate(hr), .ext_distance(ed), .is_configurator(cfg),
    .master_grant(grant), .is_master(mst), .loc_tx_valid(lv), .loc_tx_ready(lr), .loc_tx_data(ld),
    .loc_tx_last(ll), .loc_tx_port(lp), .loc_rx_valid(rv), .loc_rx_data(rd), .loc_rx_first(),
    .loc_rx_end(), .frame_reject(fr), .msg_reject(), .runt_frame(rf), .fwd_abort(), .ack_timeout(at));
  for (genvar i = 0; i < 2; i++) begin : g_far
    sln_far_port #(.HALF_CYC(2)) u_sln_far_port (.core_clk, .rst, .link(lk[i]), .half_rate(hr),
      .tx_valid(fv[i]), .tx_ready(ftr[i]), .tx_k(fk[i]), .tx_byte(fb[i]), .rx_valid(frv[i]),
      .rx_k(frk[i]), .rx_byte(fd[i]), .rx_bad());
  end
  sln_link_assertions u_sln_link_assertions (.core_clk, .rst, .dn_data(lk[0].dn_data),
    .dn_clk(lk[0].dn_clk), .up_data(lk[0].up_data), .up_clk(lk[0].up_clk), .half_rate(hr));
  always @(posedge core_clk) begin
    if (fr[0] === 1'b1) rej_seen <= 1'b1;
    if (rf[0] === 1'b1) runt_seen <= 1'b1;
    if (at[1] === 1'b1) n_tout <= n_tout + 1;
  end
  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // every wait is bounded; a stuck link ends the run
  task automatic tick(inout int n);
    n++;
    if (n > 3000) begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic far_send(input int p, input logic k, input logic [7:0] b);
    int n = 0;
    @(negedge core_clk);
    fv[p] = 1;
    fk[p] = k;
    fb[p] = b;
    do begin @(posedge core_clk); tick(n); end while (ftr[p] !== 1'b1);
  endtask
  task automatic far_frame(input int p, input logic [7:0] q[$]);
    far_send(p, 1, `SLN_K_FLAG);
    foreach (q[i]) far_send(p, 0, q[i]);
    far_send(p, 1, `SLN_K_FLAG);
    @(negedge core_clk) fv[p] = 0;
  endtask
  // idle fill is skipped, everything else must match in order
  task automatic far_expect(input int p, input logic [8:0] q[$]);
    int n = 0;
    foreach (q[i]) begin
      do begin @(negedge core_clk); tick(n); end
      while (frv[p] !== 1'b1 || {frk[p], fd[p]} === {1'b1, `SLN_K_NUL});
      chk({frk[p], fd[p]}, q[i]);
    end
  endtask
  task automatic loc_expect(input int p, input logic [7:0] q[$]);
    int n = 0;
    foreach (q[i]) begin
      do begin @(negedge core_clk); tick(n); end while (rv[p] !== 1'b1);
      chk({1'b0, rd[p]}, {1'b0, q[i]});
    end
  endtask
  task automatic loc_frame(input logic p, input logic [7:0] q[$]);
    int n = 0;
    foreach (q[i]) begin
      @(negedge core_clk);
      lv = 1;
      ld = q[i];
      ll = (i == q.size() - 1);
      lp = p;
      do begin @(posedge core_clk); tick(n); end while (lr !== 1'b1);
    end
    @(negedge core_clk) lv = 0;
  endtask
  task automatic fwd_test();
    fork
      far_frame(0, '{8'h40, 8'h02, 8'h07, 8'hAA, 8'hBB, 8'hCC, 8'hDD});
      far_expect(1, '{9'h13C, 9'h040, 9'h001, 9'h007, 9'h0AA, 9'h0BB, 9'h0CC, 9'h0DD, 9'h13C});
    join
    $display("forward done");
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 0;
    fork
      far_frame(0, '{8'h40, 8'h00, 8'h05, 8'h11, 8'h22, 8'h33, 8'h44});
      loc_expect(0, '{8'h05, 8'h11, 8'h22, 8'h33, 8'h44});
    join
    $display("local delivery done");
    fwd_test();
    far_frame(0, '{8'hC0, 8'h00, 8'h05, 8'h01, 8'h02, 8'h03, 8'h04});
    repeat (40) @(negedge core_clk);
    chk({8'h00, rej_seen}, 9'h001);
    chk({8'h00, runt_seen}, 9'h000);
    far_frame(0, '{8'h40, 8'h00, 8'h05, 8'h11});
    repeat (80) @(negedge core_clk);
    chk({8'h00, runt_seen}, 9'h001);
    $display("reserved type done");
    fork
      loc_frame(1, '{8'h4F, 8'h00, 8'h05, 8'h61, 8'h62, 8'h63, 8'h64});
      far_expect(1, '{9'h13C, 9'h048, 9'h000, 9'h005, 9'h061, 9'h062, 9'h063, 9'h064, 9'h13C});
    join
    repeat (200) @(negedge core_clk);
    chk(9'(n_tout), 9'h001);
    ed = 1;
    fork
      loc_frame(1, '{8'h40, 8'h00, 8'h05, 8'h71});
      far_expect(1, '{9'h13C, 9'h040, 9'h000, 9'h005, 9'h071, 9'h13C});
    join
    repeat (100) @(negedge core_clk);
    chk(9'(n_tout), 9'h001);
    repeat (200) @(negedge core_clk);
    chk(9'(n_tout), 9'h002);
    $display("origination done");
    cfg = 1;
    grant = 1;
    repeat (3) @(negedge core_clk);
    chk({8'h00, mst}, 9'h001);
    cfg = 0;
    repeat (3) @(negedge core_clk);
    chk({8'h00, mst}, 9'h000);
    $display("master gating done");
    // rate changes only under reset so no divider overshoots its limit
    rst = 1;
    hr = 1;
    repeat (4) @(negedge core_clk);
    rst = 0;
    fwd_test();
    complete_run();
  end
endmodule
